// ### rtl/eco_top.sv
module eco_top (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  // ahb-lite register slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // receive bytes from the mac
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_valid,
  input  wire logic        i_rx_last,
  output logic             o_rx_ready,
  // receive bytes toward the data fifo
  output logic      [7:0]  o_rx_data,
  output logic             o_rx_valid,
  output logic             o_rx_last,
  output logic      [15:0] o_rx_len,
  output logic             o_rx_len_valid,
  // transmit bytes from the data fifo
  input  wire logic [7:0]  i_tx_data,
  input  wire logic        i_tx_valid,
  input  wire logic        i_tx_last,
  input  wire logic [31:0] i_tx_cmd_a,
  input  wire logic [31:0] i_tx_cmd_b,
  output logic             o_tx_ready,
  // transmit bytes toward the mac
  output logic      [7:0]  o_tx_data,
  output logic             o_tx_valid,
  output logic             o_tx_last
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic                ahb_pend;     // data phase pending
    logic                ahb_wr;       // pending phase is a write
    logic [7:0]          ahb_addr;     // latched address
    logic [31:0]         hrdata;       // read data
    logic                hreadyout;    // always ready
    logic                rx_en;        // receive_offload_enable
    logic                rx_mode;      // receive_offload_mode
    logic                tx_en;        // transmit_offload_enable
    logic [15:0]         vlan_type;    // vlan_tag_type_register
    eco_pkg::eco_rx_st_t rx_st;        // receive output sequencer
    logic [15:0]         rx_cnt;       // bytes seen in frame
    logic [31:0]         rx_dly;       // last four bytes, newest low
    logic [15:0]         rx_type_pos;  // where the next type field sits
    logic [7:0]          rx_type_hi;   // upper type byte
    logic [1:0]          rx_vlans;     // tags skipped so far
    logic [15:0]         rx_start;     // layer three start
    logic                rx_start_ok;  // start found
    logic [15:0]         rx_sum;       // running sum
    logic [7:0]          rx_lo;        // waiting low byte
    logic                rx_odd;       // low byte waiting
    logic [15:0]         rx_csum;      // last finished sum
    logic [7:0]          rx_data;      // output byte
    logic                rx_valid;
    logic                rx_last;
    logic                rx_ready;
    logic [15:0]         rx_len;
    logic                rx_len_valid;
    logic                tx_pkt;       // inside an input packet
    logic                tx_act;       // offload on for this packet
    logic [2:0]          tx_pre_cnt;   // preamble bytes still to come
    logic [31:0]         tx_pre;       // preamble word
    logic [11:0]         tx_wr;        // bytes stored
    logic [11:0]         tx_rd;        // bytes issued to the reader
    logic                tx_done;      // input packet complete
    logic                tx_res_v;     // result final
    logic [15:0]         tx_sum;
    logic [7:0]          tx_lo;
    logic                tx_odd;
    logic [15:0]         tx_res;       // complemented result
    logic                tx_p1_v;      // read in flight
    logic                tx_p1_last;
    logic [1:0]          tx_p1_sel;    // 0 buffer, 1 result low, 2 result high
    logic [7:0]          tx_data;
    logic                tx_valid;
    logic                tx_last;
    logic                tx_ready;
  } eco_state_t;

  eco_state_t                     s;         // current state
  eco_state_t                     n;         // next state
  logic                           mem_we;    // buffer write
  logic [eco_pkg::ECO_BUF_AW-1:0] mem_wa;
  logic                           mem_re;    // buffer read
  logic [eco_pkg::ECO_BUF_AW-1:0] mem_ra;
  logic [7:0]                     mem_rd;    // buffer read data
  logic                           rx_acc;    // receive byte taken
  logic                           tx_acc;    // transmit byte taken
  logic [11:0]                    tx_start;  // sum_start_offset
  logic [11:0]                    tx_ins;    // sum_insert_offset

  // -------------------------------------------------------------------------
  // summing helpers
  // -------------------------------------------------------------------------
  // ones complement add, end-around carry
  function automatic logic [15:0] eco_oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[15:0] + {15'h0000, t[16]};
  endfunction

  // feed one byte: {odd, low byte, sum}
  function automatic logic [24:0] eco_sum_byte(input logic [15:0] sum, input logic [7:0] lo,
                                               input logic odd, input logic [7:0] b);
    if (odd) begin
      return {1'b0, lo, eco_oc_add(sum, {b, lo})};
    end
    return {1'b1, b, sum};
  endfunction

  // close a region, zero-padding an odd byte
  function automatic logic [15:0] eco_sum_fin(input logic [15:0] sum, input logic [7:0] lo,
                                              input logic odd);
    return odd ? eco_oc_add(sum, {8'h00, lo}) : sum;
  endfunction

  assign rx_acc   = i_rx_valid && s.rx_ready;
  assign tx_acc   = i_tx_valid && s.tx_ready;
  assign tx_start = s.tx_pre[eco_pkg::ECO_PRE_START_LSB +: eco_pkg::ECO_OFS_W];
  assign tx_ins   = s.tx_pre[eco_pkg::ECO_PRE_INS_LSB +: eco_pkg::ECO_OFS_W];

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb begin
    logic [24:0] acc;
    logic [15:0] t;
    logic [15:0] xi;
    logic        act;
    logic [2:0]  pcnt;
    logic [2:0]  pidx;
    logic        rd_ok;
    acc    = '0;
    t      = '0;
    xi     = '0;
    act    = 1'b0;
    pcnt   = '0;
    pidx   = '0;
    rd_ok  = 1'b0;
    n      = s;
    mem_we = 1'b0;
    mem_wa = s.tx_wr[eco_pkg::ECO_BUF_AW-1:0];
    mem_re = 1'b0;
    mem_ra = s.tx_rd[eco_pkg::ECO_BUF_AW-1:0];

    // ahb write data phase; unmapped writes fall through
    if (s.ahb_pend && s.ahb_wr) begin
      case (s.ahb_addr)
        eco_pkg::ECO_ADDR_CTRL: begin
          n.rx_en   = i_hwdata[eco_pkg::ECO_CTRL_RX_EN];
          n.rx_mode = i_hwdata[eco_pkg::ECO_CTRL_RX_MODE];
          n.tx_en   = i_hwdata[eco_pkg::ECO_CTRL_TX_EN];
        end
        eco_pkg::ECO_ADDR_VLAN: n.vlan_type = i_hwdata[15:0];
        default: ;
      endcase
    end

    // receive side: one byte out per byte in, then the two sum bytes when enabled
    n.rx_valid     = 1'b0;
    n.rx_last      = 1'b0;
    n.rx_len_valid = 1'b0;
    case (s.rx_st)
      eco_pkg::ECO_RX_APP_LO: begin
        n.rx_data = s.rx_csum[7:0];
        n.rx_valid = 1'b1;
        n.rx_st = eco_pkg::ECO_RX_APP_HI;
      end
      eco_pkg::ECO_RX_APP_HI: begin
        n.rx_data = s.rx_csum[15:8];
        n.rx_valid = 1'b1;
        n.rx_last = 1'b1;
        n.rx_st = eco_pkg::ECO_RX_PASS;
      end
      default: begin
        if (rx_acc) begin
          n.rx_data  = i_rx_data;
          n.rx_valid = 1'b1;
          n.rx_last  = i_rx_last && !s.rx_en;
          // layer three search, acts on the type field bytes
          if (s.rx_mode && s.rx_cnt == s.rx_type_pos) begin
            n.rx_type_hi = i_rx_data;
          end
          if (s.rx_mode && !s.rx_start_ok && s.rx_cnt == s.rx_type_pos + 16'h0001) begin
            t = {s.rx_type_hi, i_rx_data};
            if (t == s.vlan_type && s.rx_vlans < eco_pkg::ECO_MAX_VLANS) begin
              n.rx_vlans    = s.rx_vlans + 2'h1;
              n.rx_type_pos = s.rx_type_pos + eco_pkg::ECO_VLAN_LEN;
            end else if (t < eco_pkg::ECO_LEN_TYPE_MIN) begin
              n.rx_start    = s.rx_cnt + 16'h0001 + eco_pkg::ECO_SNAP_LEN;
              n.rx_start_ok = 1'b1;
            end else begin
              n.rx_start    = s.rx_cnt + 16'h0001;
              n.rx_start_ok = 1'b1;
            end
          end
          // the byte leaving the four-deep line is never part of the fcs
          acc = {s.rx_odd, s.rx_lo, s.rx_sum};
          xi  = s.rx_cnt - eco_pkg::ECO_FCS_LEN;
          if (s.rx_cnt >= eco_pkg::ECO_FCS_LEN &&
              (s.rx_mode ? (s.rx_start_ok && xi >= s.rx_start)
                         : (xi >= eco_pkg::ECO_MAC_HDR))) begin
            acc = eco_sum_byte(s.rx_sum, s.rx_lo, s.rx_odd, s.rx_dly[31:24]);
          end
          n.rx_odd = acc[24];
          n.rx_lo  = acc[23:16];
          n.rx_sum = acc[15:0];
          n.rx_dly = {s.rx_dly[23:0], i_rx_data};
          n.rx_cnt = s.rx_cnt + 16'h0001;
          if (i_rx_last) begin
            n.rx_len       = s.rx_cnt + 16'h0001 + (s.rx_en ? eco_pkg::ECO_RX_APPEND : 16'h0000);
            n.rx_len_valid = 1'b1;
            n.rx_csum      = eco_sum_fin(acc[15:0], acc[23:16], acc[24]);
            n.rx_st        = s.rx_en ? eco_pkg::ECO_RX_APP_LO : eco_pkg::ECO_RX_PASS;
            n.rx_cnt       = '0;
            n.rx_sum       = '0;
            n.rx_odd       = 1'b0;
            n.rx_vlans     = '0;
            n.rx_type_pos  = eco_pkg::ECO_TYPE_POS;
            n.rx_start_ok  = 1'b0;
          end
        end
      end
    endcase
    n.rx_ready = (n.rx_st == eco_pkg::ECO_RX_PASS);

    // transmit input: strip preamble, store and sum the packet
    if (tx_acc) begin
      act  = s.tx_pkt ? s.tx_act : (s.tx_en && i_tx_cmd_a[eco_pkg::ECO_CMD_A_FS] &&
                                    i_tx_cmd_b[eco_pkg::ECO_CMD_B_CK]);
      pcnt = s.tx_pkt ? s.tx_pre_cnt : (act ? eco_pkg::ECO_PRE_BYTES : 3'h0);
      n.tx_act = act;
      n.tx_pkt = !i_tx_last;
      if (pcnt != 3'h0) begin
        pidx = eco_pkg::ECO_PRE_BYTES - pcnt;
        n.tx_pre[{pidx[1:0], 3'b000} +: 8] = i_tx_data;
        n.tx_pre_cnt = pcnt - 3'h1;
      end else begin
        mem_we  = 1'b1;
        n.tx_wr = s.tx_wr + 12'h001;
        acc     = {s.tx_odd, s.tx_lo, s.tx_sum};
        if (act && s.tx_wr >= tx_start) begin
          acc = eco_sum_byte(s.tx_sum, s.tx_lo, s.tx_odd, i_tx_data);
        end
        n.tx_odd = acc[24];
        n.tx_lo  = acc[23:16];
        n.tx_sum = acc[15:0];
      end
      if (i_tx_last) begin
        n.tx_done  = 1'b1;
        n.tx_res_v = 1'b1;
        n.tx_res   = ~eco_sum_fin(acc[15:0], acc[23:16], acc[24]);
        n.tx_sum   = '0;
        n.tx_odd   = 1'b0;
      end
    end

    // transmit output stage: buffer byte or result byte
    n.tx_valid = s.tx_p1_v;
    n.tx_last  = s.tx_p1_v && s.tx_p1_last;
    case (s.tx_p1_sel)
      2'h1:    n.tx_data = s.tx_res[7:0];
      2'h2:    n.tx_data = s.tx_res[15:8];
      default: n.tx_data = mem_rd;
    endcase

    // transmit read issue; the insert bytes wait for the final sum
    rd_ok = (s.tx_rd + 12'h001 < s.tx_wr) || (s.tx_rd + 12'h001 == s.tx_wr && s.tx_done);
    n.tx_p1_v = 1'b0;
    if (rd_ok && !(s.tx_act && !s.tx_res_v && s.tx_rd >= tx_ins)) begin
      mem_re       = 1'b1;
      n.tx_p1_v    = 1'b1;
      n.tx_p1_last = (s.tx_rd + 12'h001 == s.tx_wr) && s.tx_done;
      n.tx_p1_sel  = !s.tx_act ? 2'h0 : (s.tx_rd == tx_ins) ? 2'h1 :
                     (s.tx_rd == tx_ins + 12'h001) ? 2'h2 : 2'h0;
      n.tx_rd      = s.tx_rd + 12'h001;
      if (n.tx_p1_last) begin
        n.tx_rd    = '0;
        n.tx_wr    = '0;
        n.tx_done  = 1'b0;
        n.tx_act   = 1'b0;
        n.tx_res_v = 1'b0;
      end
    end
    // one byte may still land after ready drops, hence the margin
    n.tx_ready = !n.tx_done && (n.tx_wr - n.tx_rd < eco_pkg::ECO_BUF_LIMIT);

    // ahb address phase; read data is taken from the updated registers
    n.ahb_pend = i_hsel && i_htrans[1] && i_hready;
    n.ahb_wr   = i_hwrite;
    n.ahb_addr = i_haddr[7:0];
    if (n.ahb_pend && !i_hwrite) begin
      case (i_haddr[7:0])
        eco_pkg::ECO_ADDR_CTRL: begin
          n.hrdata = '0;
          n.hrdata[eco_pkg::ECO_CTRL_RX_EN]   = n.rx_en;
          n.hrdata[eco_pkg::ECO_CTRL_RX_MODE] = n.rx_mode;
          n.hrdata[eco_pkg::ECO_CTRL_TX_EN]   = n.tx_en;
        end
        eco_pkg::ECO_ADDR_VLAN: n.hrdata = {16'h0000, n.vlan_type};
        eco_pkg::ECO_ADDR_STAT: n.hrdata = {n.tx_res, n.rx_csum};
        default:                n.hrdata = '0;
      endcase
    end
    n.hreadyout = 1'b1;

    // synchronous reset, constants only
    if (i_reset) begin
      n             = '0;
      n.vlan_type   = eco_pkg::ECO_VLAN_RESET;
      n.hreadyout   = 1'b1;
      n.rx_ready    = 1'b1;
      n.tx_ready    = 1'b1;
      n.rx_type_pos = eco_pkg::ECO_TYPE_POS;
    end
  end

  // state register
  always_ff @(posedge i_clk_sys) begin
    s <= n;
  end

  // -------------------------------------------------------------------------
  // transmit hold buffer
  // -------------------------------------------------------------------------
  eco_buf_mem u_buf (
    .i_clk_sys (i_clk_sys),
    .i_wr_en   (mem_we),
    .i_wr_addr (mem_wa),
    .i_wr_data (i_tx_data),
    .i_rd_en   (mem_re),
    .i_rd_addr (mem_ra),
    .o_rd_data (mem_rd)
  );

  // outputs, all from flops
  assign o_hrdata       = s.hrdata;
  assign o_hreadyout    = s.hreadyout;
  assign o_hresp        = 1'b0 & s.hreadyout;
  assign o_rx_ready     = s.rx_ready;
  assign o_rx_data      = s.rx_data;
  assign o_rx_valid     = s.rx_valid;
  assign o_rx_last      = s.rx_last;
  assign o_rx_len       = s.rx_len;
  assign o_rx_len_valid = s.rx_len_valid;
  assign o_tx_ready     = s.tx_ready;
  assign o_tx_data      = s.tx_data;
  assign o_tx_valid     = s.tx_valid;
  assign o_tx_last      = s.tx_last;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  default clocking eco_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  chk_rx_append_seq: assert property (
    rx_acc && i_rx_last && s.rx_en
    |=> o_rx_valid && !o_rx_last ##1 o_rx_valid && !o_rx_last ##1 o_rx_valid && o_rx_last)
    else $error("sum bytes not appended after frame");
  chk_rx_len_grow: assert property (
    rx_acc && i_rx_last && s.rx_en |=> o_rx_len_valid && o_rx_len == $past(s.rx_cnt) + 16'h0003)
    else $error("reported length not two larger");
  chk_rx_pass_thru: assert property (
    rx_acc && !s.rx_en |=> o_rx_valid && o_rx_data == $past(i_rx_data)
                         && o_rx_last == $past(i_rx_last) && o_rx_ready)
    else $error("disabled receive path altered data");
  chk_rx_vlan_skip: assert property (
    rx_acc && s.rx_mode && !s.rx_start_ok && s.rx_cnt == s.rx_type_pos + 16'h0001
    && {s.rx_type_hi, i_rx_data} == s.vlan_type && s.rx_vlans < 2'h2 && !i_rx_last
    |=> !s.rx_start_ok && s.rx_type_pos == $past(s.rx_type_pos) + 16'h0004)
    else $error("vlan tag not skipped");
  chk_tx_gate_bits: assert property (
    tx_acc && !s.tx_pkt && !(s.tx_en && i_tx_cmd_a[13] && i_tx_cmd_b[14])
    |=> !s.tx_act && s.tx_pre_cnt == 3'h0)
    else $error("offload started without all three bits");
  chk_tx_no_preamble: assert property (
    tx_acc && s.tx_pkt && s.tx_pre_cnt != 3'h0 |=> s.tx_wr == $past(s.tx_wr))
    else $error("preamble byte stored for sending");
  chk_tx_hold_ins: assert property (
    s.tx_act && !s.tx_res_v |-> s.tx_rd <= tx_ins)
    else $error("insert location passed before sum final");
  chk_tx_insert_val: assert property (
    s.tx_p1_v && s.tx_p1_sel == 2'h2 |=> o_tx_valid && o_tx_data == $past(s.tx_res[15:8]))
    else $error("inserted byte differs from result");

  cov_rx_append: cover property (o_rx_valid && o_rx_last && $past(s.rx_st) == eco_pkg::ECO_RX_APP_HI);
  cov_rx_vlan:   cover property (s.rx_vlans == 2'h2 && s.rx_start_ok);
  cov_tx_insert: cover property (o_tx_valid && $past(s.tx_p1_sel) == 2'h1);

endmodule

// ### shared/eco_pkg.sv
// ---------------------------------------------------------------------------
// constants shared by the checksum offload block
// ---------------------------------------------------------------------------
package eco_pkg;

  // register byte addresses (low address byte only is decoded)
  localparam logic [7:0]  ECO_ADDR_CTRL      = 8'h00;     // offload_control_register
  localparam logic [7:0]  ECO_ADDR_VLAN      = 8'h04;     // vlan_tag_type_register
  localparam logic [7:0]  ECO_ADDR_STAT      = 8'h08;     // last sums, read only

  // offload_control_register field positions
  localparam int          ECO_CTRL_RX_EN     = 0;         // receive_offload_enable
  localparam int          ECO_CTRL_RX_MODE   = 1;         // receive_offload_mode
  localparam int          ECO_CTRL_TX_EN     = 16;        // transmit_offload_enable

  // reset values
  localparam logic [15:0] ECO_VLAN_RESET     = 16'h8100;  // usual tag protocol id

  // receive frame layout, in bytes
  localparam logic [15:0] ECO_MAC_HDR        = 16'h000e;  // mode 0 summing start
  localparam logic [15:0] ECO_TYPE_POS       = 16'h000c;  // first type field
  localparam logic [15:0] ECO_VLAN_LEN       = 16'h0004;  // one vlan tag
  localparam logic [15:0] ECO_SNAP_LEN       = 16'h0008;  // llc plus snap header
  localparam logic [15:0] ECO_FCS_LEN        = 16'h0004;  // trailing frame check
  localparam logic [15:0] ECO_LEN_TYPE_MIN   = 16'h0600;  // below this is a length
  localparam logic [15:0] ECO_RX_APPEND      = 16'h0002;  // appended sum bytes
  localparam logic [1:0]  ECO_MAX_VLANS      = 2'h2;      // tags skipped at most

  // transmit command and preamble fields
  localparam int          ECO_CMD_A_FS       = 13;        // first_segment
  localparam int          ECO_CMD_B_CK       = 14;        // checksum_request
  localparam int          ECO_OFS_W          = 12;        // offset field width
  localparam int          ECO_PRE_START_LSB  = 0;         // sum_start_offset
  localparam int          ECO_PRE_INS_LSB    = 16;        // sum_insert_offset
  localparam logic [2:0]  ECO_PRE_BYTES      = 3'h4;      // preamble word bytes

  // transmit hold buffer
  localparam int          ECO_BUF_AW         = 11;        // 2048 bytes
  localparam logic [11:0] ECO_BUF_LIMIT      = 12'h7fc;   // stall margin

  // receive output sequencer
  typedef enum logic [1:0] {
    ECO_RX_PASS,
    ECO_RX_APP_LO,
    ECO_RX_APP_HI
  } eco_rx_st_t;

endpackage

// ### rtl/eco_buf_mem.sv
// ---------------------------------------------------------------------------
// byte buffer with registered read data
// ---------------------------------------------------------------------------
module eco_buf_mem (
  // clock
  input  wire logic                          i_clk_sys,
  // write port
  input  wire logic                          i_wr_en,
  input  wire logic [eco_pkg::ECO_BUF_AW-1:0] i_wr_addr,
  input  wire logic [7:0]                    i_wr_data,
  // read port
  input  wire logic                          i_rd_en,
  input  wire logic [eco_pkg::ECO_BUF_AW-1:0] i_rd_addr,
  output logic      [7:0]                    o_rd_data
);

  typedef struct packed {
    logic [7:0] rd_data;  // read data register
  } eco_mem_st_t;

  logic [7:0]  mem_q [0:(1 << eco_pkg::ECO_BUF_AW)-1];  // storage, no reset needed
  eco_mem_st_t s;                                      // current state
  eco_mem_st_t n;                                      // next state

  // read data only moves on a read request
  always_comb begin
    n = s;
    if (i_rd_en) begin
      n.rd_data = mem_q[i_rd_addr];
    end
  end

  // storage and read register
  always_ff @(posedge i_clk_sys) begin
    s <= n;
    if (i_wr_en) begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end

  assign o_rd_data = s.rd_data;

endmodule

// ### test/eco_mac_model.sv
// ---------------------------------------------------------------------------
// mac receive side and transmit fifo side, as byte sources
// ---------------------------------------------------------------------------
module eco_mac_model (
  // clock and back pressure from the block
  input  wire logic       i_clk_sys,
  input  wire logic       i_rx_ready,
  input  wire logic       i_tx_ready,
  // byte streams into the block
  output logic      [7:0] o_rx_data,
  output logic            o_rx_valid,
  output logic            o_rx_last,
  output logic      [7:0] o_tx_data,
  output logic            o_tx_valid,
  output logic            o_tx_last
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {o_rx_data, o_rx_valid, o_rx_last, o_tx_data, o_tx_valid, o_tx_last} = '0;
  // ready is a register, so it is read mid-cycle to dodge the edge race
  task automatic send(input bit tx, input logic [7:0] q[$]);
    bit ok;
    foreach (q[i]) begin
      if (tx) begin // preamble word leads, word aligned
        {o_tx_data, o_tx_valid, o_tx_last} <= {q[i], 1'b1, i == q.size() - 1};
      end else begin // frames keep their pad, pad removal stays off
        {o_rx_data, o_rx_valid, o_rx_last} <= {q[i], 1'b1, i == q.size() - 1};
      end
      do begin
        @(negedge i_clk_sys);
        ok = tx ? i_tx_ready : i_rx_ready;
        @(posedge i_clk_sys);
      end while (!ok);
    end
    // released data shows the inverse, never a stale copy
    if (tx) {o_tx_data, o_tx_valid, o_tx_last} <= {~o_tx_data, 2'b00};
    else {o_rx_data, o_rx_valid, o_rx_last} <= {~o_rx_data, 2'b00};
  endtask
endmodule

// ### test/ethernet_checksum_offload_bench.sv
module ethernet_checksum_offload_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] eco_byteq_t[$];
  logic        clk, rst, hsel, hwr, hrdy, rxr, rxv, rlv, txr, txv, mrv, mrl, mtv, mtl;
  logic        hrsp, rxl, txl;
  logic [1:0]  htr;
  logic [31:0] ha, hwd, hrd, ca, cb, rd;
  logic [7:0]  rxd, txd, mrd, mtd;
  logic [15:0] rlen, lenv;
  eco_byteq_t  rq, tq;
  int          n_errors, n_compared;
  int          rla, tla;
  eco_top dut_u (.i_clk_sys(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(ha),
    .i_htrans(htr), .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwd), .i_hready(hrdy),
    .o_hrdata(hrd), .o_hreadyout(hrdy), .o_hresp(hrsp), .i_rx_data(mrd), .i_rx_valid(mrv),
    .i_rx_last(mrl), .o_rx_ready(rxr), .o_rx_data(rxd), .o_rx_valid(rxv), .o_rx_last(rxl),
    .o_rx_len(rlen), .o_rx_len_valid(rlv), .i_tx_data(mtd), .i_tx_valid(mtv),
    .i_tx_last(mtl), .i_tx_cmd_a(ca), .i_tx_cmd_b(cb), .o_tx_ready(txr),
    .o_tx_data(txd), .o_tx_valid(txv), .o_tx_last(txl));
  eco_mac_model pm_u (.i_clk_sys(clk), .i_rx_ready(rxr), .i_tx_ready(txr), .o_rx_data(mrd),
    .o_rx_valid(mrv), .o_rx_last(mrl), .o_tx_data(mtd), .o_tx_valid(mtv), .o_tx_last(mtl));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // outputs stand one cycle; collected mid-cycle
  always @(negedge clk) begin
    if (rxv === 1'b1 && rxl === 1'b1) rla = rq.size() + 1;
    if (rxv === 1'b1) rq.push_back(rxd);
    if (txv === 1'b1 && txl === 1'b1) tla = tq.size() + 1;
    if (txv === 1'b1) tq.push_back(txd);
    if (rlv === 1'b1) lenv = rlen;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hwait(output logic [31:0] d);
    logic ok;
    do begin
      @(negedge clk);
      ok = hrdy;
      d = hrd;
      @(posedge clk);
    end while (ok !== 1'b1);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    {hsel, htr, ha, hwr} <= {1'b1, 2'h2, 24'h0, a, w};
    hwait(rd);
    {htr, hwd} <= {2'h0, wd};
    hwait(rd);
    chk("hresp", 0, hrsp);
  endtask
  function automatic logic [15:0] csum(input eco_byteq_t q, input int s, input int e);
    logic [16:0] a;
    a = 17'h0;
    for (int i = s; i < e; i += 2) a = a[15:0] + a[16] + {(i + 1 < e) ? q[i + 1] : 8'h00, q[i]};
    return a[15:0] + a[16];
  endfunction
  function automatic eco_byteq_t mk(input int n);
    eco_byteq_t q;
    for (int i = 0; i < n; i++) q.push_back(8'(i * 37 + 5));
    q[12] = 8'h08;
    q[13] = 8'h00;
    return q;
  endfunction
  task automatic expect_q(input bit tx, input eco_byteq_t e);
    repeat (300) if ((tx ? tq.size() : rq.size()) < e.size()) @(posedge clk);
    chk("count", e.size(), tx ? tq.size() : rq.size());
    chk("last", e.size(), tx ? tla : rla);
    foreach (e[i]) chk("byte", e[i], tx ? tq[i] : rq[i]);
    rq.delete();
    tq.delete();
    rla = 0;
    tla = 0;
  endtask
  // the sum covers s up to the frame check bytes; appended low byte first
  task automatic run_rx(input eco_byteq_t f, input int s, input bit on);
    eco_byteq_t e;
    logic [15:0] c;
    e = f;
    c = csum(f, s, f.size() - 4);
    if (on) e = {e, c[7:0], c[15:8]};
    lenv = 16'h0;
    pm_u.send(0, f);
    expect_q(0, e);
    chk("len", e.size(), lenv);
  endtask
  task automatic test_regs;
    ahb(0, 8'h00, 0); chk("ctrl", 0, rd);
    ahb(0, 8'h04, 0); chk("vlan", 32'h8100, rd);
    ahb(1, 8'h0c, 32'hffffffff);
    ahb(0, 8'h0c, 0); chk("unmapped", 0, rd);
    ahb(1, 8'h04, 32'h88a8);
    ahb(0, 8'h04, 0); chk("vlan", 32'h88a8, rd);
    $display("regs done");
  endtask
  task automatic test_rx;
    eco_byteq_t f;
    ahb(1, 8'h00, 0);
    run_rx(mk(27), 14, 0);
    ahb(1, 8'h00, 1);
    run_rx(mk(27), 14, 1);
    f = mk(31);
    {f[12], f[13], f[16], f[17]} = {8'h88, 8'ha8, 8'h08, 8'h00};
    ahb(1, 8'h00, 3);
    run_rx(f, 18, 1);
    f = mk(33);
    {f[12], f[13]} = {8'h00, 8'h20};
    run_rx(f, 22, 1);
    f = mk(33);
    {f[12], f[13], f[16], f[17], f[20], f[21]} = {3{8'h88, 8'ha8}};
    run_rx(f, 22, 1);
    $display("rx done");
  endtask
  task automatic test_tx;
    eco_byteq_t p, e;
    logic [15:0] c;
    p = mk(40);
    e = p;
    c = ~csum(p, 20, 40);
    {e[17], e[16]} = c;
    {ca, cb} <= {32'h2000, 32'h4000};
    ahb(1, 8'h00, 32'h10000);
    pm_u.send(1, {8'h14, 8'h00, 8'h10, 8'h00, p});
    expect_q(1, e);
    cb <= 32'h0;
    pm_u.send(1, p);
    expect_q(1, p);
    p = mk(28);
    {p[20], p[21], p[22], p[23], p[24], p[25], p[26], p[27]} = {16'hffff, 48'h0};
    e = p;
    {e[17], e[16]} = ~csum(p, 20, 28);
    cb <= 32'h4000;
    pm_u.send(1, {8'h14, 8'h00, 8'h10, 8'h00, p});
    expect_q(1, e);
    $display("tx done");
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    {hsel, hwr, htr, ha, hwd, ca, cb, n_errors, n_compared} = '0;
    rst = 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    test_regs;
    test_rx;
    test_tx;
    report_and_stop;
  end
endmodule
